// [brs_pkg.sv]
// Package: register offsets, command codes, field layouts and timing counts
package brs_pkg;
  localparam logic [7:0] BRS_OFF_RANGE_SEL = 8'h1D;
  localparam logic [7:0] BRS_CMD_SNAP_ALL  = 8'h00;
  localparam logic [7:0] BRS_CMD_SNAP_GEN  = 8'h1E;
  localparam logic [7:0] BRS_CMD_SNAP_KEEP = 8'h1F;
  localparam logic [7:0] BRS_RANGE_RST     = 8'h00;
  localparam int BRS_SHUNT_MSB = 7;
  localparam int BRS_RAIL_MSB  = 3;
  localparam int BRS_CLK_MHZ     = 250;
  localparam int BRS_VALID_US    = 1000;
  localparam int BRS_VALID_CYC   = BRS_VALID_US * BRS_CLK_MHZ;
  localparam int BRS_CNT_W       = 18;

  // Live measurement inputs from the front end
  typedef struct packed {
    logic [47:0] accum;
    logic [23:0] accCount;
    logic [15:0] railVoltage;
    logic [15:0] shuntVoltage;
  } brs_meas_t;

  typedef enum logic [2:0] {
    BRS_IDLE = 3'b001,
    BRS_WAIT = 3'b010,
    BRS_DONE = 3'b100
  } brs_state_t;
endpackage

// [brs_core.sv]
// Range select register and snapshot command logic for one power monitor
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bits 7:4 pick shunt format per channel
// - Bit clear: shunt unsigned, 0 to 100 mV
// - Bits 3:0 pick rail format per channel
// - Rail unsigned 0..32V or signed +-32V
// - Either bit set: power, accumulation signed
// - Snapshot is data-less send byte, code only
// - Snapshot accepted via general call address
// - Snapshot copies results; all but KEEP code clear accumulators
// - Results valid within 1 ms after snapshot
// - Results hold until next snapshot command
// - 28-bit power signed if either bipolar
// - Written settings apply only at snapshots other than KEEP
module brs_core
#(
  parameter int VALID_CYC = brs_pkg::BRS_VALID_CYC
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Decoded host command port
  input  wire logic             cmdValid,
  input  wire logic             cmdWrite,
  input  wire logic             cmdGenCall,
  input  wire logic             cmdHasData,
  input  wire logic [7:0]       cmdCode,
  input  wire logic [7:0]       cmdData,
  output logic      [7:0]       rdData,
  // Front end
  input  wire brs_pkg::brs_meas_t meas,
  output logic                  accClear,
  output logic      [3:0]       shuntSigned,
  output logic      [3:0]       railSigned,
  output logic      [3:0]       powerSigned,
  // Readable results
  output brs_pkg::brs_meas_t    results,
  output logic                  resultsValid
);

  logic [7:0]               rangePend_r, rangePend_nxt;
  logic [7:0]               rangeAct_r, rangeAct_nxt;
  logic [7:0]               rdData_nxt;
  logic                     accClear_nxt;
  logic [3:0]               powerSigned_nxt;
  brs_pkg::brs_meas_t       results_r, results_nxt;
  brs_pkg::brs_state_t      state_r, state_nxt;
  logic [brs_pkg::BRS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                     snapAny, snapClr, writeRange;

  always_comb
  begin
    // Snapshot codes act with or without the general call address
    // Send byte with no data byte
    snapAny = cmdValid && cmdWrite && !cmdHasData &&
              (cmdCode == brs_pkg::BRS_CMD_SNAP_ALL ||
               cmdCode == brs_pkg::BRS_CMD_SNAP_KEEP ||
               cmdCode == brs_pkg::BRS_CMD_SNAP_GEN);
    snapClr = snapAny && (cmdCode != brs_pkg::BRS_CMD_SNAP_KEEP);
    // Broadcast register writes are dropped so one general call
    // cannot reprogram every monitor on the bus at once
    writeRange = cmdValid && cmdWrite && cmdHasData && !cmdGenCall &&
                 cmdCode == brs_pkg::BRS_OFF_RANGE_SEL;
  end

  always_comb
  begin
    rangePend_nxt = rangePend_r;
    rangeAct_nxt  = rangeAct_r;
    results_nxt   = results_r;
    accClear_nxt  = 1'b0;
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    if (writeRange)
      rangePend_nxt = cmdData;
    if (snapAny)
    begin
      results_nxt = meas;
      if (cmdCode != brs_pkg::BRS_CMD_SNAP_KEEP)
        rangeAct_nxt = writeRange ? cmdData : rangePend_r;
      accClear_nxt = snapClr;
      state_nxt = brs_pkg::BRS_WAIT;
      cnt_nxt = '0;
    end
    else
    begin
      case (state_r)
        brs_pkg::BRS_IDLE: state_nxt = brs_pkg::BRS_IDLE;
        brs_pkg::BRS_WAIT:
        begin
          // A new snapshot restarts the count, so the wait always
          // runs from the latest command
          // Valid no later than 1 ms
          if (cnt_r == VALID_CYC[brs_pkg::BRS_CNT_W-1:0] - 1'b1)
            state_nxt = brs_pkg::BRS_DONE;
          else
            cnt_nxt = cnt_r + 1'b1;
        end
        brs_pkg::BRS_DONE: state_nxt = brs_pkg::BRS_DONE;
        default: state_nxt = brs_pkg::BRS_IDLE;
      endcase
    end
    rdData_nxt = (cmdCode == brs_pkg::BRS_OFF_RANGE_SEL) ? rangePend_nxt
                                                          : 8'h00;
  end

  // Shunt bits per channel, channel 1 at top
  // Rail bits per channel, channel 1 at bit 3
  // Power signed if either bit set
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : gChan
      assign powerSigned_nxt[ch] =
        rangeAct_nxt[brs_pkg::BRS_SHUNT_MSB-ch] |
        rangeAct_nxt[brs_pkg::BRS_RAIL_MSB-ch];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Reset leaves every channel unipolar
      rangePend_r  <= brs_pkg::BRS_RANGE_RST;
      rangeAct_r   <= brs_pkg::BRS_RANGE_RST;
      results_r    <= '0;
      state_r      <= brs_pkg::BRS_IDLE;
      cnt_r        <= '0;
      accClear     <= 1'b0;
      rdData       <= 8'h00;
      powerSigned  <= 4'h0;
    end
    else
    begin
      rangePend_r  <= rangePend_nxt;
      rangeAct_r   <= rangeAct_nxt;
      results_r    <= results_nxt;
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      accClear     <= accClear_nxt;
      rdData       <= rdData_nxt;
      powerSigned  <= powerSigned_nxt;
    end
  end

  // Zero bit gives unsigned shunt format
  // One bit gives signed shunt format
  always_comb
  begin
    shuntSigned = {rangeAct_r[4], rangeAct_r[5], rangeAct_r[6],
                   rangeAct_r[7]};
    railSigned  = {rangeAct_r[0], rangeAct_r[1], rangeAct_r[2],
                   rangeAct_r[3]};
    results      = results_r;
    // Done is the top one-hot bit, so the flag is a bare flop
    resultsValid = state_r[2];
  end

  // Command handling checks
  AST_CLEAR_ON_SNAP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    snapClr |=> accClear)
    else $error("accumulator clear missing after snapshot");
  AST_KEEP_NO_CLEAR: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (snapAny && !snapClr) |=> !accClear)
    else $error("keep snapshot cleared accumulators");
  AST_DATA_REFUSED: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cmdValid && cmdHasData) |=> !accClear)
    else $error("command with data byte cleared accumulators");
  AST_LATCH: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    snapAny |=> results == $past(meas))
    else $error("results not latched on snapshot");
  AST_HOLD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !snapAny |=> $stable(results))
    else $error("results changed without snapshot");
  AST_VALID: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (snapAny ##1 !snapAny [*8]) |->
    (state_r == brs_pkg::BRS_WAIT || resultsValid))
    else $error("snapshot wait lost");
  AST_VALID_DROP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    snapAny |=> !resultsValid)
    else $error("results flagged valid right after snapshot");

  // Register and format checks
  AST_PEND: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (writeRange && !snapAny) |=> rangeAct_r == $past(rangeAct_r))
    else $error("setting took effect without snapshot");
  AST_ACTIVATE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    snapClr |=> rangeAct_r == $past(rangePend_r))
    else $error("pending setting not activated by snapshot");
  AST_KEEP_NO_ACT: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (snapAny && !snapClr) |=> $stable(rangeAct_r))
    else $error("keep snapshot activated pending setting");
  AST_READBACK: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    writeRange |=> rangePend_r == $past(cmdData))
    else $error("range register readback wrong");
  AST_PSIGN: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    powerSigned[3] == (rangeAct_r[4] | rangeAct_r[0]))
    else $error("power sign wrong for channel 4");
  AST_PSIGN_CH1: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    powerSigned[0] == (rangeAct_r[7] | rangeAct_r[3]))
    else $error("power sign wrong for channel 1");
  AST_SHUNT1: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    shuntSigned[0] == rangeAct_r[7] && railSigned[0] == rangeAct_r[3])
    else $error("channel 1 format map wrong");
  AST_SHUNT4: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    shuntSigned[3] == rangeAct_r[4] && railSigned[3] == rangeAct_r[0])
    else $error("channel 4 format map wrong");

endmodule

`default_nettype wire

// [brs_host_model.sv]
// Host model that issues decoded commands at the falling edge
`timescale 1ns/1ps
`default_nettype none
module brs_host_model
(
  // Clock
  input  wire logic       clk_sys,
  // Command port
  output logic            cmdValid,
  output logic            cmdWrite,
  output logic            cmdGenCall,
  output logic            cmdHasData,
  output logic [7:0]      cmdCode,
  output logic [7:0]      cmdData
);
  initial
  begin
    {cmdValid, cmdWrite, cmdGenCall, cmdHasData, cmdCode, cmdData} = '0;
  end
  // send drives one command for one cycle, with data byte flag d
  task automatic send(input logic w, g, d, input logic [7:0] c, v);
    @(negedge clk_sys);
    {cmdWrite, cmdGenCall, cmdHasData, cmdCode, cmdData} = {w, g, d, c, v};
    cmdValid = 1'b1;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    // Stale data must not look valid once the command is over
    cmdData  = ~cmdData;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench for the range select register and snapshot commands
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk_sys, rst_n, accClear, resultsValid;
  logic               cmdValid, cmdWrite, cmdGenCall, cmdHasData;
  logic [7:0]         cmdCode, cmdData, rdData;
  logic [3:0]         shuntSigned, railSigned, powerSigned;
  brs_pkg::brs_meas_t meas, results, snap;
  int                 failCount, cmpCount;
  brs_host_model i_host (.clk_sys(clk_sys), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdGenCall(cmdGenCall), .cmdHasData(cmdHasData),
    .cmdCode(cmdCode), .cmdData(cmdData));
  brs_core #(.VALID_CYC(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdGenCall(cmdGenCall),
    .cmdHasData(cmdHasData), .cmdCode(cmdCode), .cmdData(cmdData),
    .rdData(rdData), .meas(meas), .accClear(accClear),
    .shuntSigned(shuntSigned), .railSigned(railSigned),
    .powerSigned(powerSigned), .results(results),
    .resultsValid(resultsValid));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [103:0] e, g);
    cmpCount++;
    if (g !== e)
    begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic endSim();
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Whole run is under 60 cycles
  initial
  begin
    #8000;
    failCount++;
    endSim();
  end
  initial
  begin
    rst_n = 1'b0;
    meas  = 104'h0123456789ABCDEF0011223344;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    i_host.send(0, 0, 0, brs_pkg::BRS_OFF_RANGE_SEL, 8'h00);
    chk("rdRst", brs_pkg::BRS_RANGE_RST, rdData);
    i_host.send(1, 0, 1, brs_pkg::BRS_OFF_RANGE_SEL, 8'hA5);
    i_host.send(1, 1, 1, brs_pkg::BRS_OFF_RANGE_SEL, 8'h3C);
    i_host.send(0, 0, 0, brs_pkg::BRS_OFF_RANGE_SEL, 8'h00);
    chk("rdBack", 8'hA5, rdData);
    chk("pending", 8'h00, {shuntSigned, railSigned});
    snap = meas;
    i_host.send(1, 1, 0, brs_pkg::BRS_CMD_SNAP_GEN, 8'h00);
    // Clear pulse stands one cycle only, so look before the next edge
    chk("resG", snap, results);
    chk("clrG", 1'b1, accClear);
    repeat (19) @(negedge clk_sys);
    // host reads only after the wait
    chk("vldEarly", 1'b0, resultsValid);
    @(negedge clk_sys);
    chk("vldLate", 1'b1, resultsValid);
    chk("shunt", 4'h5, shuntSigned);
    chk("rail", 4'hA, railSigned);
    chk("power", 4'hF, powerSigned);
    meas = ~meas;
    i_host.send(1, 0, 1, brs_pkg::BRS_CMD_SNAP_GEN, 8'h00);
    @(negedge clk_sys);
    chk("resHold", snap, results);
    i_host.send(1, 0, 1, brs_pkg::BRS_OFF_RANGE_SEL, 8'h0F);
    i_host.send(1, 0, 0, brs_pkg::BRS_CMD_SNAP_KEEP, 8'h00);
    @(negedge clk_sys);
    chk("resKeep", meas, results);
    chk("clrKeep", 1'b0, accClear);
    chk("keepPend", 4'h5, shuntSigned);
    i_host.send(1, 0, 0, brs_pkg::BRS_CMD_SNAP_ALL, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk("allAct", 8'h0F, {shuntSigned, railSigned});
    chk("allPwr", 4'hF, powerSigned);
    // Mid-run reset must drop the written range value
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    i_host.send(0, 0, 0, brs_pkg::BRS_OFF_RANGE_SEL, 8'h00);
    chk("rdRst2", brs_pkg::BRS_RANGE_RST, rdData);
    chk("actRst", 8'h00, {shuntSigned, railSigned});
    chk("vldRst", 1'b0, resultsValid);
    endSim();
  end
endmodule
`default_nettype wire
